// >>> bench/hppm_checker.sv
// Purpose: port checker for hppm_power_manager
// Assumes: I_CE held high by the bench
// Notes: bound at the foot of this file
module hppm_checker #(parameter [15:0] TIMEOUT_CYC = 16'h0014) (
  input wire I_MCLK, I_RST_N, I_CE, I_SHUTDOWN_N,
  input wire I_PLUG_DETECT_FROM_DISPLAY, I_PLUG_DETECT_INVERT_SEL,
  input wire O_PLUG_DETECT_TO_HOST, O_MAIN_LINK_OE_N, O_AUX_OE_N,
  input wire [1:0] O_POWER_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  property p_main; O_MAIN_LINK_OE_N == (O_POWER_STATE != 2'h2); endproperty
  a_main: assert property (p_main) else $error("main oe wrong");
  property p_aux; O_AUX_OE_N == (O_POWER_STATE == 2'h0); endproperty
  a_aux: assert property (p_aux) else $error("aux oe wrong");
  property p_sd; !I_SHUTDOWN_N [*3] |=> O_POWER_STATE == 2'h0; endproperty
  a_sd: assert property (p_sd) else $error("not shut down");
  property p_sdaux; !I_SHUTDOWN_N [*3] |=> O_AUX_OE_N && O_MAIN_LINK_OE_N; endproperty
  a_sdaux: assert property (p_sdaux) else $error("io driven");
  property p_on; (I_SHUTDOWN_N && I_PLUG_DETECT_FROM_DISPLAY) [*3] |=> O_POWER_STATE == 2'h2;
  endproperty
  a_on: assert property (p_on) else $error("not active");
  property p_stby; O_POWER_STATE == 2'h1 |-> !$past(I_PLUG_DETECT_FROM_DISPLAY, 3); endproperty
  a_stby: assert property (p_stby) else $error("standby late");
  property p_host; I_PLUG_DETECT_INVERT_SEL == $past(I_PLUG_DETECT_INVERT_SEL, 14) |->
    O_PLUG_DETECT_TO_HOST == ($past(I_PLUG_DETECT_FROM_DISPLAY, 13)
    ^ $past(I_PLUG_DETECT_INVERT_SEL, 13)); endproperty
  a_host: assert property (p_host) else $error("host level wrong");
  property p_to; $fell(O_POWER_STATE == 2'h2) && $past(I_SHUTDOWN_N, 3) |->
    !$past(I_PLUG_DETECT_FROM_DISPLAY, TIMEOUT_CYC + 3); endproperty
  a_to: assert property (p_to) else $error("early standby");
endmodule // hppm_checker
bind hppm_power_manager hppm_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.I_MCLK(I_MCLK),
  .I_RST_N(I_RST_N), .I_CE(I_CE), .I_SHUTDOWN_N(I_SHUTDOWN_N),
  .I_PLUG_DETECT_FROM_DISPLAY(I_PLUG_DETECT_FROM_DISPLAY),
  .I_PLUG_DETECT_INVERT_SEL(I_PLUG_DETECT_INVERT_SEL),
  .O_PLUG_DETECT_TO_HOST(O_PLUG_DETECT_TO_HOST), .O_MAIN_LINK_OE_N(O_MAIN_LINK_OE_N),
  .O_AUX_OE_N(O_AUX_OE_N), .O_POWER_STATE(O_POWER_STATE));

// >>> bench/hppm_far_model.sv
// Purpose: host and display stand-in
// Assumes: level requests from the bench
// Notes: shutdown held low until supply is good
module hppm_far_model (
  input wire logic i_clk, i_pwr_ok, i_sd_req, i_plug_req,
  output logic o_shutdown_n = 1'b0,
  output logic o_plug = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins move just after the edge
  always @(posedge i_clk)
  begin
    o_shutdown_n <= #1 i_pwr_ok & i_sd_req;
    o_plug <= #1 i_plug_req;
  end
endmodule // hppm_far_model

// >>> bench/tb_hppm_power_manager.sv
// Purpose: bench for hppm_power_manager
// Assumes: timeout shortened to 20 cycles
// Notes: reset first, then rows and timing cases
module tb_hppm_power_manager;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, sd_req = 1'b0, plug_req = 1'b0, inv = 1'b0;
  wire sd_n, plug, host, main_n, aux_n;
  wire [1:0] state;
  int n_mismatch = 0, comparisons = 0, w;
  // shutdown, plug, invert, state, host
  logic [5:0] rows [7] = '{6'b000000, 6'b010001, 6'b110101, 6'b111100, 6'b011000,
    6'b100010, 6'b110101};
  always #50 clk = ~clk;
  hppm_far_model far (.i_clk(clk), .i_pwr_ok(rst_n), .i_sd_req(sd_req),
    .i_plug_req(plug_req), .o_shutdown_n(sd_n), .o_plug(plug));
  hppm_power_manager #(.TIMEOUT_CYC(16'h0014)) dut (.I_MCLK(clk), .I_RST_N(rst_n),
    .I_CE(1'b1), .I_SHUTDOWN_N(sd_n), .I_PLUG_DETECT_FROM_DISPLAY(plug),
    .I_PLUG_DETECT_INVERT_SEL(inv), .O_PLUG_DETECT_TO_HOST(host),
    .O_MAIN_LINK_OE_N(main_n), .O_AUX_OE_N(aux_n), .O_POWER_STATE(state));
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    cyc(4);
    cmp("reset", 8'h03, 8'({state, host, main_n, aux_n}));
    rst_n = 1'b1;
    foreach (rows[k])
    begin
      {sd_req, plug_req, inv} = rows[k][5:3];
      cyc(20);
      cmp("state", 8'(rows[k][2:1]), 8'(state));
      cmp("host", 8'(rows[k][0]), 8'(host));
    end
    // short low pulse of 10 cycles passes with equal width
    w = 0;
    for (int i = 0; i < 40; i++)
    begin
      if (i == 0)
        plug_req = 1'b0;
      if (i == 10)
        plug_req = 1'b1;
      cyc(1);
      w += (host === 1'b0);
    end
    cmp("width", 8'h0a, 8'(w));
    cmp("state", 8'h02, 8'(state));
    plug_req = 1'b0;
    cyc(30);
    cmp("state", 8'h01, 8'({state}));
    cmp("link oe", 8'h02, 8'({main_n, aux_n}));
    plug_req = 1'b1;
    cyc(5);
    cmp("state", 8'h02, 8'(state));
    cmp("link oe", 8'h00, 8'({main_n, aux_n}));
    give_verdict();
  end
  // watchdog
  initial
  begin
    #100us;
    n_mismatch++;
    give_verdict();
  end
endmodule // tb_hppm_power_manager

// >>> core/hppm_delay_line.v
// Purpose: fixed delay of the plug-detect level
// Assumes: input already synchronised to i_clk
// Notes: shift register of DEPTH stages
`include "hppm_defs.vh"

module hppm_delay_line #(
  parameter DEPTH = 10
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  // data
  input wire i_d,
  output wire o_q
);

  reg [DEPTH-1:0] pipe_r;
  wire [DEPTH-1:0] pipe_nxt;

  ////////////////////////////////////////////////////////////////
  // stage chain, each stage copies the one before
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : g_stage
      if (g == 0)
      begin : g_first
        assign pipe_nxt[g] = i_d;
      end
      else
      begin : g_rest
        assign pipe_nxt[g] = pipe_r[g-1];
      end
    end
  endgenerate

  // register the chain, resets low as an unplugged line
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pipe_r <= {DEPTH{1'b0}};
    else if (i_ce)
      pipe_r <= pipe_nxt;
  end

  assign o_q = pipe_r[DEPTH-1];

endmodule // hppm_delay_line

// >>> core/hppm_power_manager.v
// Purpose: power state and plug-detect pass-through for a link repeater
// Assumes: I_MCLK 10 MHz; pins are asynchronous and synchronised here
// Notes: main link and aux enables are active-low output enables
`include "hppm_defs.vh"

module hppm_power_manager #(
  parameter [`HPPM_CNT_W-1:0] TIMEOUT_CYC = `HPPM_TIMEOUT_CYC
) (
  // clock, reset, enable
  input wire I_MCLK,
  input wire I_RST_N,
  input wire I_CE,
  // pins from host and display
  input wire I_SHUTDOWN_N,
  input wire I_PLUG_DETECT_FROM_DISPLAY,
  input wire I_PLUG_DETECT_INVERT_SEL,
  // plug detect to host
  output wire O_PLUG_DETECT_TO_HOST,
  // link gating, output enables low while driving
  output wire O_MAIN_LINK_OE_N,
  output wire O_AUX_OE_N,
  // state view
  output wire [1:0] O_POWER_STATE
);

  // power state codes, binary
  localparam [1:0] ST_SHUTDOWN = `HPPM_ST_SHUTDOWN;
  localparam [1:0] ST_STANDBY = `HPPM_ST_STANDBY;
  localparam [1:0] ST_ACTIVE = `HPPM_ST_ACTIVE;

  // synchroniser stages
  reg [1:0] shdn_sync_r;
  reg [1:0] plug_sync_r;
  reg [1:0] inv_sync_r;
  reg plug_prev_r;
  // unplug timeout
  reg [`HPPM_CNT_W-1:0] low_cnt_r;
  reg [`HPPM_CNT_W-1:0] low_cnt_nxt;
  reg timed_out_r;
  reg timed_out_nxt;
  // power state
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  // output registers
  reg host_r;
  reg main_oe_n_r;
  reg aux_oe_n_r;
  // internal views
  wire shdn_n;
  wire plug;
  wire plug_dly;
  wire plug_fall;

  ////////////////////////////////////////////////////////////////
  // state decode helpers, shared by the enable logic
  // true when the main link may drive
  function link_on;
    input [1:0] st;
    begin
      link_on = (st == ST_ACTIVE);
    end
  endfunction

  // true when every link pin must float
  function all_off;
    input [1:0] st;
    begin
      all_off = (st == ST_SHUTDOWN);
    end
  endfunction

  // synchronised pin views, only second stages are read
  assign shdn_n = shdn_sync_r[1];
  assign plug = plug_sync_r[1];
  assign plug_fall = plug_prev_r & ~plug;

  ////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the asynchronous pins
  always @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      shdn_sync_r <= 2'h0;
      plug_sync_r <= 2'h0;
      inv_sync_r <= 2'h0;
      plug_prev_r <= 1'b0;
    end
    else if (I_CE)
    begin
      shdn_sync_r <= {shdn_sync_r[0], I_SHUTDOWN_N};
      plug_sync_r <= {plug_sync_r[0], I_PLUG_DETECT_FROM_DISPLAY};
      inv_sync_r <= {inv_sync_r[0], I_PLUG_DETECT_INVERT_SEL};
      plug_prev_r <= plug;
    end
  end

  ////////////////////////////////////////////////////////////////
  // unplug timeout counter
  always @*
  begin
    low_cnt_nxt = low_cnt_r;
    timed_out_nxt = timed_out_r;
    if (plug)
    begin
      low_cnt_nxt = {`HPPM_CNT_W{1'b0}};
      timed_out_nxt = 1'b0;
    end
    else if (plug_fall)
    begin
      low_cnt_nxt = {{(`HPPM_CNT_W-1){1'b0}}, 1'b1};
      timed_out_nxt = 1'b0;
    end
    else if (!timed_out_r)
    begin
      if (low_cnt_r >= TIMEOUT_CYC)
        timed_out_nxt = 1'b1;
      else
        low_cnt_nxt = low_cnt_r + {{(`HPPM_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      low_cnt_r <= {`HPPM_CNT_W{1'b0}};
      timed_out_r <= 1'b1;
    end
    else if (I_CE)
    begin
      low_cnt_r <= low_cnt_nxt;
      timed_out_r <= timed_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // power state machine
  // shutdown pin wins over the plug level in every state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_SHUTDOWN:
      begin
        if (shdn_n)
          state_nxt = plug ? ST_ACTIVE : ST_STANDBY;
      end
      ST_STANDBY:
      begin
        if (!shdn_n)
          state_nxt = ST_SHUTDOWN;
        else if (plug)
          state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (!shdn_n)
          state_nxt = ST_SHUTDOWN;
        else if (timed_out_nxt)
          state_nxt = ST_STANDBY;
      end
      default:
        state_nxt = ST_SHUTDOWN;
    endcase
  end

  // state register, starts in shutdown until the pin releases it
  always @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state_r <= ST_SHUTDOWN;
    else if (I_CE)
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////
  // plug detect path, independent of the shutdown pin
  hppm_delay_line #(
    .DEPTH(`HPPM_PLUG_DELAY_CYC)
  ) u_delay (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_d(plug),
    .o_q(plug_dly)
  );

  // registered outputs, main link enabled only when active, aux unless shut down
  always @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      host_r <= 1'b0;
      main_oe_n_r <= 1'b1;
      aux_oe_n_r <= 1'b1;
    end
    else if (I_CE)
    begin
      host_r <= plug_dly ^ inv_sync_r[1];
      main_oe_n_r <= ~link_on(state_nxt);
      aux_oe_n_r <= all_off(state_nxt);
    end
  end

  // output views of the registers
  assign O_PLUG_DETECT_TO_HOST = host_r;
  assign O_MAIN_LINK_OE_N = main_oe_n_r;
  assign O_AUX_OE_N = aux_oe_n_r;
  assign O_POWER_STATE = state_r;

endmodule // hppm_power_manager

// >>> shared/hppm_defs.vh
// Purpose: constants for the plug-detect power manager
// Assumes: 10 MHz core clock
// Notes: times in ns, counts derived from the clock period
`ifndef HPPM_DEFS_VH
`define HPPM_DEFS_VH

`define HPPM_CLK_PERIOD_NS 100
// unplug timeout, plain default
`define HPPM_UNPLUG_TIMEOUT_NS 2000000
// plug detect propagation delay, plain default
`define HPPM_PLUG_DELAY_NS 1000
// delay in cycles, rounded down, at least one
`define HPPM_PLUG_DELAY_CYC ((`HPPM_PLUG_DELAY_NS / `HPPM_CLK_PERIOD_NS) < 1 ? 1 : \
  (`HPPM_PLUG_DELAY_NS / `HPPM_CLK_PERIOD_NS))
// unplug timeout in cycles, sized to the counter: 2000000 ns / 100 ns
`define HPPM_TIMEOUT_CYC 16'h4e20
`define HPPM_CNT_W 16
`define HPPM_DLY_W 8

// power states
`define HPPM_ST_SHUTDOWN 2'h0
`define HPPM_ST_STANDBY 2'h1
`define HPPM_ST_ACTIVE 2'h2

`endif
